// ---- inc/a16_bank_pkg.sv ----
// shared constants, reset values and types for the a16 register bank
package a16_bank_pkg;
  // ----------------------------------------
  // address space
  // ----------------------------------------
  localparam logic [15:0] A16_START   = 16'hC000;
  localparam int          BLOCK_BITS  = 6;
  localparam int          WIDE_BITS   = 18;
  localparam int          WIDE_TAGW   = 24 - WIDE_BITS;
  // ----------------------------------------
  // register offsets inside the block
  // ----------------------------------------
  localparam logic [5:0] OFS_IDENT    = 6'h00;
  localparam logic [5:0] OFS_DEVTYPE  = 6'h02;
  localparam logic [5:0] OFS_STATCTL  = 6'h04;
  localparam logic [5:0] OFS_WIDEBASE = 6'h06;
  localparam logic [5:0] OFS_CAL      = 6'h08;
  localparam logic [5:0] OFS_CARDCFG  = 6'h0A;
  localparam logic [5:0] OFS_TRIGCTL  = 6'h0E;
  localparam logic [5:0] OFS_INTCTL   = 6'h10;
  localparam logic [5:0] OFS_INTSTAT  = 6'h12;
  localparam logic [5:0] OFS_ISO      = 6'h14;
  localparam logic [5:0] OFS_PROGSEL  = 6'h16;
  localparam logic [5:0] OFS_CHTRIG   = 6'h18;
  localparam logic [5:0] OFS_OUTTYPE  = 6'h1A;
  localparam logic [5:0] OFS_RELAY    = 6'h1C;
  localparam logic [5:0] OFS_CARDCTL  = 6'h1E;
  localparam logic [5:0] OFS_WINDOW   = 6'h20;
  // ----------------------------------------
  // reset values and fields
  // ----------------------------------------
  localparam logic [15:0] RST_ZERO    = 16'h0000;
  localparam logic [15:0] RST_ONES    = 16'hFFFF;
  localparam logic [15:0] RST_CAL     = 16'h2000;
  localparam logic [15:0] RST_TRIG8   = 16'hFF00;
  localparam logic [7:0]  UPPER_ONES  = 8'hFF;
  localparam int          SOFT_RST_BIT = 0;
  localparam int          WIN_LSB     = 0;
  localparam int          WIN_W       = 4;
  localparam int          WIDE_TAG_LSB = 10;
  // ----------------------------------------
  // bus cycle states
  // ----------------------------------------
  typedef enum logic {ST_IDLE, ST_ACK} cycle_st_t;
endpackage

// ---- verilog/a16_register_bank.sv ----
// a16 register bank: bus slave, decode, reset states and channel control registers
`timescale 1ns/100ps
// What this block does
// R1 - block base is C000 hex plus logical address times 64 in a16 space
// R2 - block spans 64 bytes; register address is base plus offset
// R3 - status read and control write sit at offset 04
// R4 - logical address from switches or a write; decoding follows the new value
// R5 - host uses only 8-bit or 16-bit transfers
// R6 - power-on loads every register with its reset state; soft reset reloads all but the wide base and logical address
// R7 - identity and device type registers are untouched by any reset
// R8 - output type at 1A resets to FFFF, or to jumpers when jumper selected
// R9 - program select at 16 resets to FFFF, or to the jumper positions
// R10 - relay control at 1C resets to FFFF, all relays open
// R11 - isolation status at 14 shows each channel isolated or not
// R12 - calibration control at 08 resets to 2000 hex
// R13 - channel trigger at 18 resets to 0000, or FF00 in 8-channel build
// R14 - 8-channel build holds upper byte of channel registers at ones
// R15 - four-bit window select in card control at 1E picks the a24 group
// R16 - wide space base register holds upper a24 lines; a24 decodes against it
// R17 - writes to read-only or empty offsets ignored, cycle completes normally
module a16_register_bank #(
  parameter int          CHANNELS = 16,
  parameter logic [15:0] IDENT    = 16'h1234,  // arbitrary value
  parameter logic [15:0] DEVTYPE  = 16'h5678,  // arbitrary value
  parameter logic [15:0] CARDCFG  = 16'h0000
) (
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST,
  // bus pins
  input  wire logic [23:1] ADDR,
  input  wire logic        AM_WIDE,
  input  wire logic        AS_N,
  input  wire logic [1:0]  DS_N,
  input  wire logic        WRITE_N,
  input  wire logic [15:0] D_IN,
  output logic      [15:0] D_OUT,
  output logic             D_OE,
  output logic             DTACK_N,
  output logic             DTACK_OE,
  // straps and jumpers
  input  wire logic [7:0]  LA_SWITCH,
  input  wire logic        JUMPER_SELECT,
  input  wire logic [15:0] PROG_JUMPER,
  input  wire logic [15:0] TYPE_JUMPER,
  input  wire logic [15:0] ISO_BUILD,
  // channel controls
  output logic      [15:0] RELAY_OPEN,
  output logic      [15:0] OUT_TYPE,
  output logic      [15:0] PROG_SELECT,
  output logic      [15:0] CHAN_TRIGGER,
  output logic      [15:0] CAL_CONTROL,
  output logic [3:0]       WINDOW_SEL
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    a16_bank_pkg::cycle_st_t st;
    logic        init;
    logic        por;        // power-on load of the switch address pending
    logic [1:0]  settle;     // init cycles left while strap synchronisers fill
    logic [22:0] addr1, addr2;
    logic [1:0]  ctl1, ctl2;     // wide modifier, write_n
    logic [2:0]  str1, str2;     // as_n, ds_n[1:0]
    logic [15:0] din1, din2;
    logic [7:0]  la1, la2;
    logic        js1, js2;
    logic [15:0] pj1, pj2, tj1, tj2, iso1, iso2;
    logic [7:0]  logical_address;
    logic [15:0] ctrl, wbase, cal, trigctl, intctl, intstat;
    logic [15:0] prog, chtrig, otype, relay, cardctl;
    logic [15:0] rdata;
  } state_t;

  state_t q, d;

  // strap synchronisers leave reset cleared, so init lasts until they carry the pins
  localparam logic [1:0] SETTLE_CYCLES = 2'd2;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // per-channel value with absent channels forced high
  function automatic logic [15:0] chmask(input logic [15:0] v);
    chmask = (CHANNELS == 8) ? {a16_bank_pkg::UPPER_ONES, v[7:0]} : v;
  endfunction

  // byte lane merge: ds_n[1] even (high) byte, ds_n[0] odd (low) byte
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                         input logic [1:0] dsn);
    merge = {dsn[1] ? old[15:8] : nw[15:8], dsn[0] ? old[7:0] : nw[7:0]};
  endfunction

  // ----------------------------------------
  // decode
  // ----------------------------------------
  logic [15:0] base16;
  logic        hit16;
  logic        hit24;
  logic        hit;
  logic        strobe;
  logic        wr;
  logic [5:0]  ofs;

  // base follows the live logical address, so a reassignment takes effect at once
  assign base16 = a16_bank_pkg::A16_START + {2'b00, q.logical_address, 6'b00_0000}; // R1 R4
  assign hit16  = !q.ctl2[1] &&
                  (q.addr2[14:a16_bank_pkg::BLOCK_BITS-1] == base16[15:a16_bank_pkg::BLOCK_BITS]); // R1 R2
  assign hit24  = q.ctl2[1] && (q.addr2[22:a16_bank_pkg::WIDE_BITS-1] ==
                  q.wbase[15:a16_bank_pkg::WIDE_TAG_LSB]); // R16
  assign strobe = !q.str2[2] && (q.str2[1:0] != 2'b11);
  assign hit    = strobe && (hit16 || hit24);
  assign wr     = !q.ctl2[0];
  assign ofs    = {q.addr2[a16_bank_pkg::BLOCK_BITS-2:0], 1'b0}; // R2

  // ----------------------------------------
  // next state
  // ----------------------------------------
  // one process for sync, access and reset loading
  always_comb begin
    d       = q;
    d.init  = 1'b0;
    // hold init until the straps have passed both flops; the last init cycle wins
    if (q.settle != 2'd0) begin
      d.settle = q.settle - 2'd1;
      d.init   = 1'b1;
    end
    // two-stage synchronisers on every pin
    d.addr1 = ADDR;
    d.addr2 = q.addr1;
    d.ctl1  = {AM_WIDE, WRITE_N};
    d.ctl2  = q.ctl1;
    d.str1  = {AS_N, DS_N};
    d.str2  = q.str1;
    d.din1  = D_IN;
    d.din2  = q.din1;
    d.la1   = LA_SWITCH;
    d.la2   = q.la1;
    d.js1   = JUMPER_SELECT;
    d.js2   = q.js1;
    d.pj1   = PROG_JUMPER;
    d.pj2   = q.pj1;
    d.tj1   = TYPE_JUMPER;
    d.tj2   = q.tj1;
    d.iso1  = ISO_BUILD;
    d.iso2  = q.iso1;
    // bus cycle: one access per strobe, dtack held until strobes drop
    unique case (q.st)
      a16_bank_pkg::ST_IDLE: begin
        if (hit && !q.init) begin
          d.st    = a16_bank_pkg::ST_ACK; // R17
          d.rdata = a16_bank_pkg::RST_ZERO;
          if (hit16) begin
            unique case (ofs)
              a16_bank_pkg::OFS_IDENT:    d.rdata = IDENT;    // R7
              a16_bank_pkg::OFS_DEVTYPE:  d.rdata = DEVTYPE;  // R7
              a16_bank_pkg::OFS_STATCTL:  d.rdata = q.ctrl;   // R3
              a16_bank_pkg::OFS_WIDEBASE: d.rdata = q.wbase;
              a16_bank_pkg::OFS_CAL:      d.rdata = q.cal;
              a16_bank_pkg::OFS_CARDCFG:  d.rdata = CARDCFG;
              a16_bank_pkg::OFS_TRIGCTL:  d.rdata = q.trigctl;
              a16_bank_pkg::OFS_INTCTL:   d.rdata = q.intctl;
              a16_bank_pkg::OFS_INTSTAT:  d.rdata = q.intstat;
              a16_bank_pkg::OFS_ISO:      d.rdata = chmask(q.iso2); // R11
              a16_bank_pkg::OFS_PROGSEL:  d.rdata = q.prog;
              a16_bank_pkg::OFS_CHTRIG:   d.rdata = q.chtrig;
              a16_bank_pkg::OFS_OUTTYPE:  d.rdata = q.otype;
              a16_bank_pkg::OFS_RELAY:    d.rdata = q.relay;
              a16_bank_pkg::OFS_CARDCTL:  d.rdata = q.cardctl;
              default:                    d.rdata = a16_bank_pkg::RST_ZERO;
            endcase
          end
          // writes: read-only and empty offsets fall through untouched
          if (hit16 && wr) begin
            unique case (ofs)
              a16_bank_pkg::OFS_IDENT: begin
                if (!q.str2[0])
                  d.logical_address = q.din2[7:0]; // R4
              end
              a16_bank_pkg::OFS_STATCTL: begin
                d.ctrl = merge(q.ctrl, q.din2, q.str2[1:0]); // R3
                d.ctrl[a16_bank_pkg::SOFT_RST_BIT] = 1'b0;
                if (!q.str2[0] && q.din2[a16_bank_pkg::SOFT_RST_BIT])
                  d.init = 1'b1; // R6
              end
              a16_bank_pkg::OFS_WIDEBASE: d.wbase   = merge(q.wbase, q.din2, q.str2[1:0]); // R16
              a16_bank_pkg::OFS_CAL:      d.cal     = merge(q.cal, q.din2, q.str2[1:0]);
              a16_bank_pkg::OFS_TRIGCTL:  d.trigctl = merge(q.trigctl, q.din2, q.str2[1:0]);
              a16_bank_pkg::OFS_INTCTL:   d.intctl  = merge(q.intctl, q.din2, q.str2[1:0]);
              a16_bank_pkg::OFS_INTSTAT:  d.intstat = merge(q.intstat, q.din2, q.str2[1:0]);
              a16_bank_pkg::OFS_PROGSEL:  d.prog    = chmask(merge(q.prog, q.din2, q.str2[1:0]));   // R14
              a16_bank_pkg::OFS_CHTRIG:   d.chtrig  = chmask(merge(q.chtrig, q.din2, q.str2[1:0])); // R14
              a16_bank_pkg::OFS_OUTTYPE:  d.otype   = chmask(merge(q.otype, q.din2, q.str2[1:0]));  // R14
              a16_bank_pkg::OFS_RELAY:    d.relay   = chmask(merge(q.relay, q.din2, q.str2[1:0]));  // R14
              a16_bank_pkg::OFS_CARDCTL:  d.cardctl = merge(q.cardctl, q.din2, q.str2[1:0]); // R15
              default: ;                                                                   // R17
            endcase
          end
        end
      end
      a16_bank_pkg::ST_ACK: begin
        if (q.str2[1:0] == 2'b11)
          d.st = a16_bank_pkg::ST_IDLE;
      end
    endcase
    // reset loading; jumpers are sampled only after the reset release
    if (q.init) begin
      d.ctrl    = a16_bank_pkg::RST_ZERO;                                           // R6
      d.cal     = a16_bank_pkg::RST_CAL;                                            // R12
      d.relay   = chmask(a16_bank_pkg::RST_ONES);                                   // R10
      d.chtrig  = (CHANNELS == 8) ? a16_bank_pkg::RST_TRIG8 : a16_bank_pkg::RST_ZERO; // R13
      d.prog    = q.js2 ? chmask(q.pj2) : chmask(a16_bank_pkg::RST_ONES);           // R9
      d.otype   = q.js2 ? chmask(q.tj2) : chmask(a16_bank_pkg::RST_ONES);           // R8
      d.trigctl = a16_bank_pkg::RST_ZERO;
      d.intctl  = a16_bank_pkg::RST_ZERO;
      d.intstat = a16_bank_pkg::RST_ZERO;
      d.cardctl = a16_bank_pkg::RST_ZERO;
      // switches give the logical address on power-on only; soft reset keeps it
      if (q.por)
        d.logical_address = q.la2;                                                            // R4
      if (q.settle == 2'd0)
        d.por = 1'b0;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  // async reset holds constants only; straps land on the init cycle
  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      q       <= '0;
      q.st    <= a16_bank_pkg::ST_IDLE;
      q.init  <= 1'b1;
      q.por   <= 1'b1;
      q.settle <= SETTLE_CYCLES;
      q.str1  <= 3'h7;
      q.str2  <= 3'h7;
      q.ctl1  <= 2'h1;
      q.ctl2  <= 2'h1;
      q.logical_address <= 8'h00;
      q.cal   <= a16_bank_pkg::RST_CAL;
      q.relay <= a16_bank_pkg::RST_ONES;
      q.prog  <= a16_bank_pkg::RST_ONES;
      q.otype <= a16_bank_pkg::RST_ONES;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign D_OUT        = q.rdata;
  assign D_OE         = (q.st == a16_bank_pkg::ST_ACK) && q.ctl2[0];
  assign DTACK_N      = !(q.st == a16_bank_pkg::ST_ACK);
  assign DTACK_OE     = (q.st == a16_bank_pkg::ST_ACK);
  assign RELAY_OPEN   = q.relay;
  assign OUT_TYPE     = q.otype;
  assign PROG_SELECT  = q.prog;
  assign CHAN_TRIGGER = q.chtrig;
  assign CAL_CONTROL  = q.cal;
  assign WINDOW_SEL   = q.cardctl[a16_bank_pkg::WIN_LSB +: a16_bank_pkg::WIN_W]; // R15

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_ack_needs_hit;
    $rose(!DTACK_N) |-> $past(hit);
  endproperty
  a_ack_needs_hit: assert property (p_ack_needs_hit) else $error("dtack without address hit"); // R1

  property p_ack_follows;
    (q.st == a16_bank_pkg::ST_IDLE && hit && !q.init) |=> !DTACK_N;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("decoded cycle not acknowledged"); // R17

  property p_release;
    (!DTACK_N && q.str2[1:0] == 2'b11) |=> DTACK_N;
  endproperty
  a_release: assert property (p_release) else $error("dtack held after strobes released"); // R2

  property p_relay_rst;
    q.init |=> RELAY_OPEN == chmask(a16_bank_pkg::RST_ONES);
  endproperty
  a_relay_rst: assert property (p_relay_rst) else $error("relay reset value wrong"); // R10

  property p_cal_rst;
    q.init |=> CAL_CONTROL == a16_bank_pkg::RST_CAL;
  endproperty
  a_cal_rst: assert property (p_cal_rst) else $error("calibration reset value wrong"); // R12

  property p_trig_rst;
    q.init |=> CHAN_TRIGGER == ((CHANNELS == 8) ? a16_bank_pkg::RST_TRIG8 : a16_bank_pkg::RST_ZERO);
  endproperty
  a_trig_rst: assert property (p_trig_rst) else $error("channel trigger reset value wrong"); // R13

  property p_type_rst;
    q.init |=> OUT_TYPE == ($past(q.js2) ? chmask($past(q.tj2)) : chmask(a16_bank_pkg::RST_ONES));
  endproperty
  a_type_rst: assert property (p_type_rst) else $error("output type reset value wrong"); // R8

  property p_prog_rst;
    q.init |=> PROG_SELECT == ($past(q.js2) ? chmask($past(q.pj2)) : chmask(a16_bank_pkg::RST_ONES));
  endproperty
  a_prog_rst: assert property (p_prog_rst) else $error("program select reset value wrong"); // R9

  property p_upper_ones;
    (CHANNELS == 8) |-> (RELAY_OPEN[15:8] == a16_bank_pkg::UPPER_ONES && OUT_TYPE[15:8] == a16_bank_pkg::UPPER_ONES);
  endproperty
  a_upper_ones: assert property (p_upper_ones) else $error("upper channel byte not ones"); // R14

  property p_soft_rst;
    (q.st == a16_bank_pkg::ST_IDLE && hit && hit16 && wr && !q.init && ofs == a16_bank_pkg::OFS_STATCTL
     && !q.str2[0] && q.din2[a16_bank_pkg::SOFT_RST_BIT]) |=> ##1 RELAY_OPEN == chmask(a16_bank_pkg::RST_ONES);
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset did not reload relays"); // R6

  property p_logical_address_wr;
    (q.st == a16_bank_pkg::ST_IDLE && hit && hit16 && wr && !q.init && ofs == a16_bank_pkg::OFS_IDENT
     && !q.str2[0]) |=> q.logical_address == $past(q.din2[7:0]);
  endproperty
  a_logical_address_wr: assert property (p_logical_address_wr) else $error("logical address not updated"); // R4

  property p_logical_address_por;
    (q.init && q.por) |=> q.logical_address == $past(q.la2);
  endproperty
  a_logical_address_por: assert property (p_logical_address_por) else $error("switch address not loaded at power-on"); // R4

  property p_init_no_take;
    (q.init && q.st == a16_bank_pkg::ST_IDLE) |=> DTACK_N;
  endproperty
  a_init_no_take: assert property (p_init_no_take) else $error("cycle taken during reset loading"); // R6

  property p_wide_zero;
    (q.st == a16_bank_pkg::ST_IDLE && hit && hit24 && !q.init) |=> D_OUT == a16_bank_pkg::RST_ZERO;
  endproperty
  a_wide_zero: assert property (p_wide_zero) else $error("wide space read not zero"); // R16

  c_read:   cover property ($rose(D_OE));
  c_write:  cover property ($rose(!DTACK_N) && $past(wr));
  c_wide:   cover property ($rose(!DTACK_N) && $past(hit24));
  c_soft:   cover property (q.init && !q.por);
  c_jumper: cover property (q.init && q.js2 && q.settle == 2'd0);
endmodule

// ---- tb/bus_master_model.sv ----
// bus master model that runs one a16 or a24 strobe cycle at a time
`timescale 1ns/100ps
module bus_master_model (
  // clock
  input  wire logic        clk,
  // bus pins towards the slave
  output logic      [23:1] addr,
  output logic             am_wide,
  output logic             as_n,
  output logic      [1:0]  ds_n,
  output logic             write_n,
  output logic      [15:0] d_in,
  // slave answer
  input  wire logic        dtack_n
);
  // ----------------------------------------
  // idle levels at time zero
  // ----------------------------------------
  initial begin
    addr    = '0;
    am_wide = 1'b0;
    as_n    = 1'b1;
    ds_n    = 2'b11;
    write_n = 1'b1;
    d_in    = 16'h0000;
  end
  // ----------------------------------------
  // one strobe cycle, held until dtack is sampled low or 12 edges have passed
  // ----------------------------------------
  // released address and data lines show the inverse so a stale value never looks valid
  task automatic cycle(input logic [23:0] a, input logic wide, input logic wr_n,
                       input logic [1:0] ds, input logic [15:0] wd, output logic acked);
    int n;
    n = 0;
    @(posedge clk);
    addr    <= a[23:1];
    am_wide <= wide;
    write_n <= wr_n;
    d_in    <= wd;
    as_n    <= 1'b0;
    ds_n    <= ds;
    do begin
      @(posedge clk);
      n++;
    end while (dtack_n !== 1'b0 && n < 12);
    acked = (dtack_n === 1'b0);
    as_n <= 1'b1;
    ds_n <= 2'b11;
    d_in <= ~wd;
    addr <= ~a[23:1];
    n = 0;
    // no new strobe until the slave has let dtack go, or 12 edges have passed
    do begin
      @(posedge clk);
      n++;
    end while (dtack_n !== 1'b1 && n < 12);
  endtask
endmodule

// ---- tb/vxi_a16_register_decode_reset_tb.sv ----
// self-checking bench for the a16 register bank
`timescale 1ns/100ps
module vxi_a16_register_decode_reset_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  localparam logic [15:0] ID_V = 16'h2B4D;  // arbitrary value
  localparam logic [15:0] DT_V = 16'h3C71;  // arbitrary value
  logic        clk, rst, am_wide, as_n, write_n, d_oe, dtack_n, dtack_oe, jsel, ack, seen;
  logic [23:1] addr;
  logic [1:0]  ds_n;
  logic [15:0] d_in, d_out, pjmp, tjmp, iso, relay, otype, psel, ctrig, cal, base, v;
  logic [3:0]  win;
  logic [15:0] relay8, otype8, psel8, ctrig8;
  logic [15:0] wv [8];
  logic [15:0] q [$];
  int          error_cnt, cmp_count;
  logic [5:0]  rw_ofs [8] = '{6'h08, 6'h0E, 6'h10, 6'h12, 6'h16, 6'h18, 6'h1A, 6'h1C};
  // ----------------------------------------
  // design and bus master
  // ----------------------------------------
  a16_register_bank #(.CHANNELS(16), .IDENT(ID_V), .DEVTYPE(DT_V), .CARDCFG(16'h0000)) i_dut (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .AM_WIDE(am_wide), .AS_N(as_n), .DS_N(ds_n),
    .WRITE_N(write_n), .D_IN(d_in), .D_OUT(d_out), .D_OE(d_oe), .DTACK_N(dtack_n),
    .DTACK_OE(dtack_oe), .LA_SWITCH(8'h48), .JUMPER_SELECT(jsel), .PROG_JUMPER(pjmp),
    .TYPE_JUMPER(tjmp), .ISO_BUILD(iso), .RELAY_OPEN(relay), .OUT_TYPE(otype),
    .PROG_SELECT(psel), .CHAN_TRIGGER(ctrig), .CAL_CONTROL(cal), .WINDOW_SEL(win));
  // eight-channel build on the same pins at its own address, checked for its reset states
  a16_register_bank #(.CHANNELS(8), .IDENT(ID_V), .DEVTYPE(DT_V), .CARDCFG(16'h0000)) i_dut8 (
    .REF_CLK(clk), .RST(rst), .ADDR(addr), .AM_WIDE(am_wide), .AS_N(as_n), .DS_N(ds_n),
    .WRITE_N(write_n), .D_IN(d_in), .D_OUT(), .D_OE(), .DTACK_N(), .DTACK_OE(),
    .LA_SWITCH(8'h30), .JUMPER_SELECT(jsel), .PROG_JUMPER(pjmp), .TYPE_JUMPER(tjmp),
    .ISO_BUILD(iso), .RELAY_OPEN(relay8), .OUT_TYPE(otype8), .PROG_SELECT(psel8),
    .CHAN_TRIGGER(ctrig8), .CAL_CONTROL(), .WINDOW_SEL());
  bus_master_model i_master (.clk(clk), .addr(addr), .am_wide(am_wide), .as_n(as_n),
    .ds_n(ds_n), .write_n(write_n), .d_in(d_in), .dtack_n(dtack_n));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ofs, input logic [15:0] d, input logic [1:0] ds = 2'b00);
    i_master.cycle({8'h00, base + 16'(ofs)}, 1'b0, 1'b0, ds, d, ack);
    chk(16'(ack), 16'h0001, "write ack");
  endtask
  // the expected word is noted before the cycle starts
  task automatic rd(input logic [5:0] ofs, input logic [15:0] exp);
    q.push_back(exp);
    i_master.cycle({8'h00, base + 16'(ofs)}, 1'b0, 1'b1, 2'b00, 16'h0000, ack);
    chk(16'(ack), 16'h0001, "read ack");
  endtask
  task automatic defaults(input logic js);
    chk(relay, 16'hFFFF, "relay reset");
    chk(otype, js ? tjmp : 16'hFFFF, "type reset");
    chk(psel, js ? pjmp : 16'hFFFF, "prog reset");
    chk(cal, 16'h2000, "cal reset");
    chk(ctrig, 16'h0000, "trig reset");
    chk(16'(win), 16'h0000, "window reset");
    chk(relay8, 16'hFFFF, "relay reset 8ch");
    chk(ctrig8, 16'hFF00, "trig reset 8ch");
    chk(otype8, js ? {8'hFF, tjmp[7:0]} : 16'hFFFF, "type reset 8ch");
    chk(psel8, js ? {8'hFF, pjmp[7:0]} : 16'hFFFF, "prog reset 8ch");
  endtask
  // straps change at reset entry, well ahead of the two-flop synchroniser
  task automatic hw_reset(input logic js);
    @(posedge clk);
    rst  <= 1'b1;
    jsel <= js;
    pjmp <= 16'($urandom);
    tjmp <= 16'($urandom);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    // reset loading spans three edges while the straps pass the synchronisers
    repeat (4) @(posedge clk);
    base = 16'hC000 + 16'h0048 * 16'h0040;
  endtask
  task automatic give_verdict;
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // ----------------------------------------
  // clock, watchdog and read watcher
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict;
  end
  // one compare per read acknowledge, on its first cycle
  always @(posedge clk) begin
    if (d_oe === 1'b1 && !seen) begin
      if (q.size() == 0) begin
        error_cnt++;
        $display("MISMATCH %0t read without note", $time);
      end else chk(d_out, q.pop_front(), "read data");
    end
    seen <= (d_oe === 1'b1);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h8a1e));
    rst = 1'b1;
    jsel = 1'b0;
    pjmp = 16'h0000;
    tjmp = 16'h0000;
    iso = 16'($urandom);
    seen = 1'b0;
    error_cnt = 0;
    cmp_count = 0;
    hw_reset(1'b0);
    defaults(1'b0);
    rd(6'h00, ID_V);
    rd(6'h02, DT_V);
    rd(6'h14, iso);
    for (int i = 0; i < 8; i++) begin
      wv[i] = 16'($urandom);
      wr(rw_ofs[i], wv[i]);
    end
    for (int i = 0; i < 8; i++) rd(rw_ofs[i], wv[i]);
    chk(cal, wv[0], "cal port");
    chk(psel, wv[4], "prog port");
    chk(ctrig, wv[5], "trig port");
    chk(otype, wv[6], "type port");
    // byte lanes merge into the word
    wr(6'h1C, 16'hA5C3, 2'b10);
    rd(6'h1C, {wv[7][15:8], 8'hC3});
    wr(6'h1C, 16'h5A3C, 2'b01);
    chk(relay, 16'h5AC3, "relay port");
    // read-only places keep their contents, an empty place reads zero
    wr(6'h02, ~DT_V);
    rd(6'h02, DT_V);
    wr(6'h14, ~iso);
    rd(6'h14, iso);
    rd(6'h20, 16'h0000);
    wr(6'h1E, 16'h0009);
    chk(16'(win), 16'h0009, "window port");
    // wide space decode follows the base register
    v = 16'($urandom);
    wr(6'h06, v);
    rd(6'h06, v);
    q.push_back(16'h0000);
    i_master.cycle({v[15:10], 18'h00040}, 1'b1, 1'b1, 2'b00, 16'h0000, ack);
    chk(16'(ack), 16'h0001, "wide hit");
    i_master.cycle({~v[15:10], 18'h00040}, 1'b1, 1'b1, 2'b00, 16'h0000, ack);
    chk(16'(ack), 16'h0000, "wide miss");
    // dynamic address moves the block
    wr(6'h00, 16'h0021, 2'b10);
    i_master.cycle({8'h00, base + 16'h0008}, 1'b0, 1'b1, 2'b00, 16'h0000, ack);
    chk(16'(ack), 16'h0000, "old base");
    base = 16'hC000 + 16'h0021 * 16'h0040;
    rd(6'h08, wv[0]);
    // soft reset reloads channel state, not identity or wide base
    wr(6'h04, 16'h0001, 2'b10);
    defaults(1'b0);
    rd(6'h00, ID_V);
    rd(6'h06, v);
    // mid-run reset with jumper selection
    hw_reset(1'b1);
    defaults(1'b1);
    rd(6'h02, DT_V);
    chk(16'(q.size()), 16'h0000, "reads left over");
    give_verdict;
  end
endmodule
